/* File: design/phy_irq_pkg.sv */
/*
 * Constants for the status-summary and interrupt-control block: register
 * offsets, field positions, reset values and event bit layout.
 * Assumes an 8-bit-free plain register port with 16-bit data words.
 */
// How it works
// - Status bit 2 reports full duplex.
// - Duplex/speed valid only with qualified link.
// - Status bit 1 reports 10 Mb/s speed.
// - Status bit 0 mirrors link, never read-cleared.
// - Link copy is 1 while link valid.
// - Control bits 15:4 ignore writes, read zero.
// - Select 1: time-sync bit 11, speed-or-duplex 12.
// - Select 0: duplex bit 11, speed bit 12.
// - Test bit keeps interrupt asserted while set.
// - Global enable gates event-based interrupts.
// - Output enable 1 drives shared pin.
// - Output enable 0: pin is power-down input.
// - Sources: quality, energy, link, speed, duplex, negotiation, counters.
// - Event bits latch always, clear on read.
// - Time-sync event re-arms only when status empty.
// - Summary pending bit clears after event status read while test bit clear.
package phy_irq_pkg;

    localparam int REG_ADDR_W = 5;
    localparam int REG_DATA_W = 16;
    localparam int EVT_W = 8;

    localparam logic [REG_ADDR_W-1:0] ADDR_STATUS_SUMMARY = 5'h10;
    localparam logic [REG_ADDR_W-1:0] ADDR_PIN_CONTROL = 5'h11;
    localparam logic [REG_ADDR_W-1:0] ADDR_EVENT_STATUS = 5'h12;

    // Status summary fields.
    localparam int SUM_LINK_BIT = 0;
    localparam int SUM_SPEED10_BIT = 1;
    localparam int SUM_DUPLEX_BIT = 2;
    localparam int SUM_PENDING_BIT = 7;

    // Interrupt pin control fields.
    localparam int CTL_PIN_OE_BIT = 0;
    localparam int CTL_GLOBAL_EN_BIT = 1;
    localparam int CTL_TEST_FORCE_BIT = 2;
    localparam int CTL_TS_SEL_BIT = 3;
    localparam logic CTL_RESET = 1'b0;

    // Event status: pending flags in the high byte, enables in the low byte.
    localparam int EVT_STATUS_LSB = 8;
    localparam int EVT_ENABLE_LSB = 0;
    localparam logic [EVT_W-1:0] EVT_ENABLE_RESET = 8'h00;

    // Event index within a byte (register bit minus the byte base).
    localparam int EVT_LINK_QUALITY = 7;
    localparam int EVT_ENERGY = 6;
    localparam int EVT_LINK = 5;
    localparam int EVT_SPEED = 4;
    localparam int EVT_DUPLEX_OR_TS = 3;
    localparam int EVT_AN_COMPLETE = 2;
    localparam int EVT_COUNTER_HALF = 1;
    localparam int EVT_SPARE = 0;

    localparam logic [REG_DATA_W-1:0] READ_ZERO = 16'h0000;

endpackage

/* File: design/event_flag_bank.sv */
/*
 * Bank of sticky event flags cleared as a group by one clear pulse.
 * Assumes set and clear pulses come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module event_flag_bank #(
    parameter int WIDTH = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic [WIDTH-1:0] i_set,
    input wire logic i_clear,
    output logic [WIDTH-1:0] o_flags
);

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } flag_state_t;

    flag_state_t st;
    flag_state_t next_st;

    ////////////////////////////////////////////////////////////////////////////

    // A set in the clearing cycle wins so that no event is lost.
    always_comb begin
        next_st = st;
        for (int i = 0; i < WIDTH; i++) begin
            next_st.flags[i] = i_set[i] | (st.flags[i] & ~i_clear);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_flags = st.flags;

endmodule // event_flag_bank

`default_nettype wire

/* File: design/phy_status_irq_control.sv */
/*
 * Status summary and interrupt control of the transceiver management block:
 * read-only link/speed/duplex summary, interrupt pin control register and
 * the latched event status with its enables.
 * Assumes link, speed and duplex levels and the event pulses come from
 * logic on i_clk_sys; only the shared pin arrives from outside.
 */
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module phy_status_irq_control
    import phy_irq_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Register port.
    input wire logic [REG_ADDR_W-1:0] i_addr,
    input wire logic [REG_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [REG_DATA_W-1:0] o_rdata,
    // Resolved link state from the negotiation and link monitor logic.
    input wire logic i_link_up,
    input wire logic i_speed_10,
    input wire logic i_full_duplex,
    // Event pulses from neighbouring monitors.
    input wire logic i_link_quality_event,
    input wire logic i_energy_event,
    input wire logic i_an_complete_event,
    input wire logic i_counter_half_event,
    // Level: the time-sync status still holds unread entries.
    input wire logic i_timesync_pending,
    // Shared power-down / interrupt pin.
    input wire logic i_powerdown_irq_pin_in,
    output logic o_powerdown_irq_pin_out,
    output logic o_powerdown_irq_pin_oe,
    output logic o_powerdown_req,
    // Level interrupt toward the rest of the chip.
    output logic o_irq
);

    typedef struct packed {
        logic ts_sel;
        logic test_force;
        logic global_en;
        logic pin_oe;
        logic [EVT_W-1:0] enables;
        logic link_d;
        logic speed_d;
        logic duplex_d;
        logic ts_armed;
        logic [1:0] pin_sync;
        logic irq;
        logic [REG_DATA_W-1:0] rdata;
    } ctrl_state_t;

    ctrl_state_t st;
    ctrl_state_t next_st;

    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_flags;
    logic evt_clear;
    logic link_change;
    logic speed_change;
    logic duplex_change;
    logic timesync_event;
    logic event_pending;
    logic irq_now;
    logic [REG_DATA_W-1:0] summary_word;
    logic [REG_DATA_W-1:0] control_word;
    logic [REG_DATA_W-1:0] event_word;

    ////////////////////////////////////////////////////////////////////////////
    // Event detection.

    // Changes are seen against last cycle's level, so a change lasting one
    // cycle still raises its flag.
    assign link_change = i_link_up ^ st.link_d;
    assign speed_change = i_speed_10 ^ st.speed_d;
    assign duplex_change = i_full_duplex ^ st.duplex_d;

    // One event per burst of time-sync status; the host must drain it first.
    assign timesync_event = st.ts_armed & i_timesync_pending;

    always_comb begin
        evt_set = '0;
        evt_set[EVT_LINK_QUALITY] = i_link_quality_event;
        evt_set[EVT_ENERGY] = i_energy_event;
        evt_set[EVT_LINK] = link_change;
        evt_set[EVT_AN_COMPLETE] = i_an_complete_event;
        evt_set[EVT_COUNTER_HALF] = i_counter_half_event;
        evt_set[EVT_SPARE] = 1'b0;
        if (st.ts_sel) begin
            evt_set[EVT_DUPLEX_OR_TS] = timesync_event;
            evt_set[EVT_SPEED] = speed_change | duplex_change;
        end else begin
            evt_set[EVT_DUPLEX_OR_TS] = duplex_change;
            evt_set[EVT_SPEED] = speed_change;
        end
    end

    assign evt_clear = i_rd && (i_addr == ADDR_EVENT_STATUS);

    event_flag_bank #(
        .WIDTH(EVT_W)
    ) u_flags (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_set(evt_set),
        .i_clear(evt_clear),
        .o_flags(evt_flags)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt combination.

    // Flags latch regardless of enables; only the output path is gated.
    assign event_pending = st.global_en & (|(evt_flags & st.enables));
    assign irq_now = event_pending | st.test_force;

    ////////////////////////////////////////////////////////////////////////////
    // Read words.

    always_comb begin
        summary_word = READ_ZERO;
        // Levels are passed as resolved; software qualifies them with link
        // and negotiation state before trusting speed and duplex.
        summary_word[SUM_DUPLEX_BIT] = i_full_duplex;
        summary_word[SUM_SPEED10_BIT] = i_speed_10;
        summary_word[SUM_LINK_BIT] = i_link_up;
        summary_word[SUM_PENDING_BIT] = irq_now;
    end

    always_comb begin
        control_word = READ_ZERO;
        control_word[CTL_TS_SEL_BIT] = st.ts_sel;
        control_word[CTL_TEST_FORCE_BIT] = st.test_force;
        control_word[CTL_GLOBAL_EN_BIT] = st.global_en;
        control_word[CTL_PIN_OE_BIT] = st.pin_oe;
    end

    always_comb begin
        event_word = READ_ZERO;
        event_word[EVT_STATUS_LSB +: EVT_W] = evt_flags;
        event_word[EVT_ENABLE_LSB +: EVT_W] = st.enables;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        next_st = st;

        next_st.link_d = i_link_up;
        next_st.speed_d = i_speed_10;
        next_st.duplex_d = i_full_duplex;

        // Disarm while status remains, re-arm once it has been drained.
        next_st.ts_armed = ~i_timesync_pending;

        next_st.pin_sync = {st.pin_sync[0], i_powerdown_irq_pin_in};

        next_st.irq = irq_now;

        if (i_wr) begin
            unique case (i_addr)
                ADDR_PIN_CONTROL: begin
                    // Upper bits are simply not stored.
                    next_st.ts_sel = i_wdata[CTL_TS_SEL_BIT];
                    next_st.test_force = i_wdata[CTL_TEST_FORCE_BIT];
                    next_st.global_en = i_wdata[CTL_GLOBAL_EN_BIT];
                    next_st.pin_oe = i_wdata[CTL_PIN_OE_BIT];
                end
                ADDR_EVENT_STATUS: begin
                    next_st.enables = i_wdata[EVT_ENABLE_LSB +: EVT_W];
                end
                default: begin
                end
            endcase
        end

        // Read data stand only in the cycle after the strobe.
        next_st.rdata = READ_ZERO;
        if (i_rd) begin
            unique case (i_addr)
                ADDR_STATUS_SUMMARY: begin
                    next_st.rdata = summary_word;
                end
                ADDR_PIN_CONTROL: begin
                    next_st.rdata = control_word;
                end
                ADDR_EVENT_STATUS: begin
                    next_st.rdata = event_word;
                end
                default: begin
                    next_st.rdata = READ_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st.ts_sel <= CTL_RESET;
            st.test_force <= CTL_RESET;
            st.global_en <= CTL_RESET;
            st.pin_oe <= CTL_RESET;
            st.enables <= EVT_ENABLE_RESET;
            st.link_d <= 1'b0;
            st.speed_d <= 1'b0;
            st.duplex_d <= 1'b0;
            st.ts_armed <= 1'b1;
            // Idle pin level is high, so power-down is not requested.
            st.pin_sync <= 2'b11;
            st.irq <= 1'b0;
            st.rdata <= READ_ZERO;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign o_rdata = st.rdata;
    assign o_irq = st.irq;

    // Active-low interrupt signalling on the shared pin.
    assign o_powerdown_irq_pin_out = ~st.irq;
    assign o_powerdown_irq_pin_oe = st.pin_oe;

    // The pin acts as an active-low power-down request only as an input.
    assign o_powerdown_req = ~st.pin_oe & ~st.pin_sync[1];

endmodule // phy_status_irq_control

`default_nettype wire

/* File: sim/phy_irq_sva.sv */
/* Checker for the status summary and interrupt control block.
   Sees only the top module's ports; one clock, async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module phy_irq_sva
    import phy_irq_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic [REG_ADDR_W-1:0] i_addr,
    input wire logic [REG_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [REG_DATA_W-1:0] o_rdata,
    input wire logic i_link_up,
    input wire logic i_speed_10,
    input wire logic i_full_duplex,
    input wire logic i_powerdown_irq_pin_in,
    input wire logic o_powerdown_irq_pin_out,
    input wire logic o_powerdown_irq_pin_oe,
    input wire logic o_powerdown_req,
    input wire logic o_irq
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    wire ctl_wr = i_wr && i_addr == ADDR_PIN_CONTROL;
    wire rd_ctl = i_rd && i_addr == ADDR_PIN_CONTROL;
    wire rd_sum = i_rd && i_addr == ADDR_STATUS_SUMMARY;
    ////////////////////////////////////////////////////////////////////////
    property p_oe;
        ctl_wr |=> o_powerdown_irq_pin_oe == $past(i_wdata[0]);
    endproperty
    a_oe: assert property (p_oe) else $error("pin enable not taken");
    property p_pin;
        o_powerdown_irq_pin_oe |-> o_powerdown_irq_pin_out == !o_irq;
    endproperty
    a_pin: assert property (p_pin) else $error("pin level wrong");
    property p_rsv;
        rd_ctl |=> o_rdata[15:4] == 12'h000;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_link;
        rd_sum |=> o_rdata[0] == $past(i_link_up);
    endproperty
    a_link: assert property (p_link) else $error("link copy wrong");
    property p_spd;
        rd_sum |=> o_rdata[1] == $past(i_speed_10);
    endproperty
    a_spd: assert property (p_spd) else $error("speed bit wrong");
    property p_dup;
        rd_sum |=> o_rdata[2] == $past(i_full_duplex);
    endproperty
    a_dup: assert property (p_dup) else $error("duplex bit wrong");
    property p_test;
        ctl_wr && i_wdata[2] |-> ##2 o_irq;
    endproperty
    a_test: assert property (p_test) else $error("test irq missing");
    property p_gate;
        ctl_wr && i_wdata[2:1] == 2'b00 |-> ##2 !o_irq;
    endproperty
    a_gate: assert property (p_gate) else $error("irq while gated");
    property p_pdreq;
        $past(o_powerdown_irq_pin_oe) && o_powerdown_irq_pin_oe |-> !o_powerdown_req;
    endproperty
    a_pdreq: assert property (p_pdreq) else $error("power-down in output mode");
    property p_pdsync;
        !o_powerdown_irq_pin_oe && !i_powerdown_irq_pin_in ##1
            !o_powerdown_irq_pin_oe && !i_powerdown_irq_pin_in
            |=> o_powerdown_req || o_powerdown_irq_pin_oe;
    endproperty
    a_pdsync: assert property (p_pdsync) else $error("power-down request missing");
    c_test: cover property (ctl_wr && i_wdata[2]);
    c_irq: cover property ($rose(o_irq) && o_powerdown_irq_pin_oe);
    c_pd: cover property ($rose(o_powerdown_req));
endmodule // phy_irq_sva
bind phy_status_irq_control phy_irq_sva i_phy_irq_sva (.*);
`default_nettype wire

/* File: sim/pin_host_model.sv */
/* Host side of the shared power-down / interrupt pin.
   Assumes a board pull-up; the host may pull the pin low itself. */
`timescale 1ns/1ps
`default_nettype none
module pin_host_model (
    input wire logic i_oe,
    input wire logic i_out,
    input wire logic i_pd_low,
    output logic o_level
);
    // Undriven pin floats to the pull-up unless the host pulls it low with i_pd_low to request power-down.
    always_comb o_level = i_oe ? i_out : !i_pd_low;
endmodule // pin_host_model
`default_nettype wire

/* File: sim/tb.sv */
/* Self-checking bench for the status and interrupt control block.
   Register port accessed by tasks; pin host model closes the pin. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import phy_irq_pkg::*;
    localparam logic [4:0] SUM = ADDR_STATUS_SUMMARY;
    localparam logic [4:0] CTL = ADDR_PIN_CONTROL;
    localparam logic [4:0] EVT = ADDR_EVENT_STATUS;
    localparam logic [15:0] ALL = 16'hFFFF;
    logic clk, rst_b, wr, rd, lnk, spd, dup, lq, ed, an, ch, ts, pd;
    logic oe, pout, pdr, irq, pin;
    logic [4:0] ad;
    logic [15:0] wd, rdata;
    logic [7:0] src [4] = '{8'h80, 8'h40, 8'h04, 8'h02};
    int n_errors = 0;
    int cmp_count = 0;
    phy_status_irq_control i_phy_status_irq_control (.i_clk_sys(clk), .i_rst_b(rst_b),
        .i_addr(ad), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_link_up(lnk), .i_speed_10(spd), .i_full_duplex(dup),
        .i_link_quality_event(lq), .i_energy_event(ed), .i_an_complete_event(an),
        .i_counter_half_event(ch), .i_timesync_pending(ts),
        .i_powerdown_irq_pin_in(pin), .o_powerdown_irq_pin_out(pout),
        .o_powerdown_irq_pin_oe(oe), .o_powerdown_req(pdr), .o_irq(irq));
    pin_host_model i_pin_host_model (.i_oe(oe), .i_out(pout), .i_pd_low(pd), .o_level(pin));
    initial begin
        clk = 1'b0;
        forever #10 clk = !clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // For a read, d is the expected word and m masks the bits compared.
    task acc(input logic w, input logic [4:0] a, input logic [15:0] d, input logic [15:0] m);
        @(posedge clk);
        ad <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        if (!w) chk(rdata & m, d & m);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Toggle one level input, let its flag land, then read events back.
    task ev(input int s, input logic [15:0] e);
        @(posedge clk);
        case (s)
            0: dup <= !dup;
            1: spd <= !spd;
            2: ts <= !ts;
            default: lnk <= !lnk;
        endcase
        cyc(2);
        acc(0, EVT, e, ALL);
    endtask
    task report_and_stop;
        $display("Compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_b, wr, rd, lnk, spd, dup, lq, ed, an, ch, ts, pd} = '0;
        ad = '0;
        wd = '0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        cyc(1);
        chk({oe, pout, irq}, 3'b010);
        acc(0, CTL, 16'h0000, ALL);
        acc(1, CTL, ALL, 0);
        acc(0, CTL, 16'h000F, ALL);
        chk({oe, irq}, 2'b11);
        acc(0, SUM, 16'h0080, ALL);
        acc(1, CTL, 16'h0000, 0);
        cyc(1);
        chk(irq, 0);
        $display("control done");
        for (int v = 0; v < 8; v++) begin
            @(posedge clk);
            {dup, spd, lnk} <= v[2:0];
            acc(0, SUM, 16'(v), ALL);
            acc(0, SUM, 16'(v), ALL);
        end
        $display("summary done");
        // Every level toggled in the sweep, so duplex, speed and link flags stand.
        acc(0, EVT, 16'h3800, ALL);
        acc(1, EVT, ALL, 0);
        acc(0, EVT, 16'h00FF, ALL);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            {lq, ed, an, ch} <= 4'b1000 >> k;
            @(posedge clk);
            {lq, ed, an, ch} <= '0;
            cyc(2);
            chk(irq, 0);
            acc(0, EVT, {src[k], 8'hFF}, ALL);
        end
        ev(3, 16'h20FF);
        acc(1, CTL, 16'h0003, 0);
        @(posedge clk);
        ed <= 1'b1;
        @(posedge clk);
        ed <= 1'b0;
        cyc(2);
        chk({irq, pout}, 2'b10);
        acc(0, EVT, 16'h40FF, ALL);
        cyc(1);
        chk({irq, pout}, 2'b01);
        $display("events done");
        acc(1, CTL, 16'h0000, 0);
        ev(0, 16'h08FF);
        ev(1, 16'h10FF);
        acc(1, CTL, 16'h0008, 0);
        ev(0, 16'h10FF);
        ev(2, 16'h08FF);
        acc(0, EVT, 16'h00FF, ALL);
        ev(2, 16'h00FF);
        ev(2, 16'h08FF);
        $display("select done");
        @(posedge clk);
        pd <= 1'b1;
        for (int k = 0; k < 6 && pdr !== 1'b1; k++) cyc(1);
        chk(pdr, 1);
        if (pdr !== 1'b1) report_and_stop();
        acc(1, CTL, 16'h0001, 0);
        cyc(2);
        chk({pdr, pin}, 2'b01);
        $display("pin done");
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
